// ---- include/axis_ref_pkg.sv ----
// constants shared by the axis position-reference logic
package axis_ref_pkg;
  // ----------------------------------------
  // register byte offsets
  // ----------------------------------------
  localparam logic [7:0] CMD_ADR      = 8'h00;
  localparam logic [7:0] HOME_OFS_ADR = 8'h04;
  localparam logic [7:0] ROLL_LO_ADR  = 8'h08;
  localparam logic [7:0] ROLL_HI_ADR  = 8'h0C;
  localparam logic [7:0] CFG_ADR      = 8'h10;
  localparam logic [7:0] WARN_FE_ADR  = 8'h14;
  localparam logic [7:0] DEST_ADR     = 8'h18;
  localparam logic [7:0] MPOS_ADR     = 8'h1C;
  localparam logic [7:0] APOS_ADR     = 8'h20;

  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_OP_W      = 3;
  localparam int CMD_HNEG_BIT  = 3;
  localparam int ST_BUSY_BIT   = 0;
  localparam int ST_HOMED_BIT  = 1;
  localparam int ST_ABSREF_BIT = 2;
  localparam int CFG_FLAG_LSB  = 0;
  localparam int CFG_FLAG_W    = 2;
  localparam int CFG_ROT_BIT   = 4;
  localparam int CFG_SEL_LSB   = 8;
  localparam int SEL_W         = 4;
  localparam int OFS_W         = 24;
  localparam int ROLL_W        = 36;
  localparam int ROLL_HI_W     = 4;
  localparam int POS_W         = 32;
  localparam int CALC_W        = 40;
  localparam int OFS_FRAC      = 4;

  // ----------------------------------------
  // command codes
  // ----------------------------------------
  localparam logic [2:0] OP_ABS    = 3'h1;
  localparam logic [2:0] OP_INC    = 3'h2;
  localparam logic [2:0] OP_JOG    = 3'h3;
  localparam logic [2:0] OP_RELOAD = 3'h4;
  localparam logic [2:0] OP_HOME   = 3'h5;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [23:0] HOME_OFS_RST = 24'h000000;
  localparam logic [35:0] ROLL_RST     = 36'h000000000;
  localparam logic [31:0] WARN_FE_RST  = 32'h00001000;
  localparam logic [1:0]  FLAG_SEL_RST = 2'h0;

  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS      = 5;
  localparam int STEP_NS     = 1000;
  localparam int STEP_CYCLES = STEP_NS / CLK_NS;
  localparam int STEP_CNT_W  = 8;
  localparam logic [1:0] INIT_WAIT = 2'h3;
endpackage

// ---- core/step_divider.sv ----
// step-rate enable pulse generator
`timescale 1ns/1ps
module step_divider (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // enable pulse
  output logic      tick_o
);
  localparam logic [axis_ref_pkg::STEP_CNT_W-1:0] LAST =
    axis_ref_pkg::STEP_CNT_W'(axis_ref_pkg::STEP_CYCLES - 1);

  logic [axis_ref_pkg::STEP_CNT_W-1:0] cnt_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_r  <= '0;
      tick_o <= 1'b0;
    end else begin
      tick_o <= (cnt_r == LAST);
      cnt_r  <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
    end
  end

  tick_period_a : assert property (@(posedge clk_i) disable iff (rst_i)
    tick_o |=> !tick_o [*8]) else $error("step tick too frequent");
endmodule

// ---- core/rollover_target.sv ----
// absolute-move distance with rotary rollover
`timescale 1ns/1ps
module rollover_target (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // request
  input  wire logic        start_i,
  input  wire logic        rotary_i,
  input  wire logic [35:0] range_i,
  input  wire logic [31:0] cur_i,
  input  wire logic [31:0] dest_i,
  // answer
  output logic [31:0]      delta_o,
  output logic             valid_o
);
  localparam int W = axis_ref_pkg::CALC_W;

  // remainder folded into [0, m)
  function automatic logic signed [W-1:0] mod_pos(input logic signed [W-1:0] x,
                                                  input logic signed [W-1:0] m);
    logic signed [W-1:0] r;
    r = x % m;
    if (r < 0) begin
      r = r + m;
    end
    return r;
  endfunction

  logic signed [W-1:0] rng, d, c, rev, t, cp, dl;

  always_comb begin
    rng = W'($signed(range_i));
    d   = W'($signed(dest_i));
    c   = W'($signed(cur_i));
    rev = -rng;
    t   = '0;
    cp  = '0;
    if (!rotary_i || rng == 0) begin
      dl = d - c;
    end else if (rng > 0) begin
      dl = mod_pos(d - c, rng);
      if (dl > (rng >>> 1)) begin
        dl = dl - rng;
      end
    end else begin
      t  = mod_pos(d, rev);
      cp = mod_pos(c, rev);
      if (d < 0) begin
        dl = -mod_pos(cp - t, rev);
      end else begin
        dl = mod_pos(t - cp, rev);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      valid_o <= 1'b0;
      delta_o <= '0;
    end else begin
      valid_o <= start_i;
      if (start_i) begin
        delta_o <= dl[31:0];
      end
    end
  end

  half_rev_a : assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && rotary_i && rng > 0 |=> W'($signed(delta_o)) <= ($past(rng) >>> 1)
      && W'($signed(delta_o)) >= -($past(rng) >>> 1)) else $error("shortest path exceeded");
  sign_dir_a : assert property (@(posedge clk_i) disable iff (rst_i)
    start_i && rotary_i && rng < 0 |=> ($past(dest_i[31]) ? !(delta_o > 0 && !delta_o[31])
      : !delta_o[31]) && W'($signed(delta_o)) < $past(rev)) else $error("wrong direction");
endmodule

// ---- core/axis_ref_core.sv ----
// home offset, absolute reference and rotary rollover for one axis
`timescale 1ns/1ps
// Function
// - With a zero absolute-source selection the position is cleared to zero at reset.
// - A homing search keeps stepping until the chosen flag or excess following error trips.
// - After the trigger the axis stops at the home offset from it and calls that zero.
// - The home offset is signed 24-bit in sixteenths of a count.
// - With a nonzero selection, position is the sensor reading minus the home offset.
// - Rollover applies only with a nonzero range on an axis marked rotary.
// - A positive range gives shortest-path absolute moves of at most half a revolution.
// - A negative range lets the destination sign pick the direction, under one revolution.
// - A negative destination is reached moving negatively, others moving positively.
// - A zero range disables rollover so absolute moves are linear.
// - Incremental and jog moves travel exactly the commanded distance.
// - Reported position is never wrapped.
module axis_ref_core (
  // clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // motor side
  input  wire logic [31:0] enc_count_i,
  input  wire logic [3:0]  home_flag_i,
  input  wire logic [31:0] abs_sensor_i,
  input  wire logic [3:0]  abs_position_source_sel_i,
  // status
  output logic [31:0]      cmd_pos_o,
  output logic             busy_o,
  output logic             homed_o
);
  typedef enum logic [2:0] {
    ST_INIT, ST_IDLE, ST_PLAN, ST_MOVE, ST_HSEARCH, ST_HOFFS
  } mstate_t;

  // ----------------------------------------
  // byte-lane merge
  // ----------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  logic [31:0] enc_m, enc_s, abs_m, abs_s;
  logic [3:0]  flag_m, flag_s, sel_m, sel_s;

  always_ff @(posedge clk_i) begin
    enc_m  <= enc_count_i;
    enc_s  <= enc_m;
    abs_m  <= abs_sensor_i;
    abs_s  <= abs_m;
    flag_m <= home_flag_i;
    flag_s <= flag_m;
    sel_m  <= abs_position_source_sel_i;
    sel_s  <= sel_m;
  end

  // ----------------------------------------
  // register file
  // ----------------------------------------
  logic [23:0] home_offset_param_r;
  logic [35:0] rollover_range_param_r;
  logic [31:0] warning_following_error_limit_r;
  logic [31:0] dest_r;
  logic [1:0]  flag_channel_select_r;
  logic        rotary_r;
  logic [3:0]  sel_cap_r;
  logic        ack_r, wb_fire, cmd_go;
  logic [31:0] wr_val;
  logic [2:0]  cmd_op;
  logic        homed_r, busy_r;
  mstate_t     state_r;
  logic [31:0] cmd_raw_r, origin_r, target_r, mpos, apos;

  assign wb_fire = wb_cyc_i && wb_stb_i && !ack_r;
  assign cmd_go  = wb_fire && wb_we_i && wb_adr_i == axis_ref_pkg::CMD_ADR && wb_sel_i[0];
  assign cmd_op  = wb_dat_i[axis_ref_pkg::CMD_OP_LSB +: axis_ref_pkg::CMD_OP_W];
  assign wr_val  = wb_dat_i;
  assign mpos    = cmd_raw_r - origin_r;
  assign apos    = enc_s - origin_r;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      home_offset_param_r             <= axis_ref_pkg::HOME_OFS_RST;
      rollover_range_param_r          <= axis_ref_pkg::ROLL_RST;
      warning_following_error_limit_r <= axis_ref_pkg::WARN_FE_RST;
      flag_channel_select_r           <= axis_ref_pkg::FLAG_SEL_RST;
      rotary_r                        <= 1'b0;
      dest_r                          <= '0;
    end else if (wb_fire && wb_we_i) begin
      case (wb_adr_i)
        axis_ref_pkg::HOME_OFS_ADR: begin
          home_offset_param_r <= 24'(merge({8'h00, home_offset_param_r}, wr_val, wb_sel_i));
        end
        axis_ref_pkg::ROLL_LO_ADR: begin
          rollover_range_param_r[31:0] <= merge(rollover_range_param_r[31:0], wr_val, wb_sel_i);
        end
        axis_ref_pkg::ROLL_HI_ADR: begin
          if (wb_sel_i[0]) begin
            rollover_range_param_r[35:32] <= wr_val[3:0];
          end
        end
        axis_ref_pkg::CFG_ADR: begin
          if (wb_sel_i[0]) begin
            flag_channel_select_r <= wr_val[axis_ref_pkg::CFG_FLAG_LSB +: axis_ref_pkg::CFG_FLAG_W];
            rotary_r              <= wr_val[axis_ref_pkg::CFG_ROT_BIT];
          end
        end
        axis_ref_pkg::WARN_FE_ADR: begin
          warning_following_error_limit_r <= merge(warning_following_error_limit_r, wr_val,
                                                   wb_sel_i);
        end
        axis_ref_pkg::DEST_ADR: begin
          dest_r <= merge(dest_r, wr_val, wb_sel_i);
        end
        default: begin
        end
      endcase
    end
  end

  // unmapped addresses still answer, reading zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_r    <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      ack_r <= wb_fire;
      if (wb_fire && !wb_we_i) begin
        case (wb_adr_i)
          axis_ref_pkg::CMD_ADR:      wb_dat_o <= {29'h0, sel_cap_r != 4'h0, homed_r, busy_r};
          axis_ref_pkg::HOME_OFS_ADR: wb_dat_o <= {{8{home_offset_param_r[23]}},
                                                   home_offset_param_r};
          axis_ref_pkg::ROLL_LO_ADR:  wb_dat_o <= rollover_range_param_r[31:0];
          axis_ref_pkg::ROLL_HI_ADR:  wb_dat_o <= {{28{rollover_range_param_r[35]}},
                                                   rollover_range_param_r[35:32]};
          axis_ref_pkg::CFG_ADR:      wb_dat_o <= {20'h0, sel_cap_r, 3'h0, rotary_r,
                                                   2'h0, flag_channel_select_r};
          axis_ref_pkg::WARN_FE_ADR:  wb_dat_o <= warning_following_error_limit_r;
          axis_ref_pkg::DEST_ADR:     wb_dat_o <= dest_r;
          axis_ref_pkg::MPOS_ADR:     wb_dat_o <= mpos;
          axis_ref_pkg::APOS_ADR:     wb_dat_o <= apos;
          default:                    wb_dat_o <= '0;
        endcase
      end
    end
  end
  assign wb_ack_o = ack_r;

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  logic        tick, rt_start, rt_valid, hdir_neg_r, trig;
  logic [31:0] rt_delta, ofs_counts, fe, fe_mag;
  logic [1:0]  init_cnt_r;

  // offset truncates toward minus infinity to whole counts
  assign ofs_counts = 32'($signed({{8{home_offset_param_r[23]}}, home_offset_param_r})
                          >>> axis_ref_pkg::OFS_FRAC);
  assign fe         = cmd_raw_r - enc_s;
  assign fe_mag     = fe[31] ? -fe : fe;
  assign trig       = flag_s[flag_channel_select_r] || fe_mag > warning_following_error_limit_r;
  assign rt_start   = state_r == ST_IDLE && cmd_go && cmd_op == axis_ref_pkg::OP_ABS;

  step_divider u_div (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .tick_o (tick)
  );

  // one planning pass per absolute move
  rollover_target u_roll (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .start_i  (rt_start),
    .rotary_i (rotary_r),
    .range_i  (rollover_range_param_r),
    .cur_i    (mpos),
    .dest_i   (dest_r),
    .delta_o  (rt_delta),
    .valid_o  (rt_valid)
  );

  // ----------------------------------------
  // motion sequencer
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r    <= ST_INIT;
      init_cnt_r <= 2'h0;
      cmd_raw_r  <= '0;
      origin_r   <= '0;
      target_r   <= '0;
      homed_r    <= 1'b0;
      hdir_neg_r <= 1'b0;
      sel_cap_r  <= 4'h0;
    end else begin
      case (state_r)
        ST_INIT: begin
          // lets the synchronisers fill before sampling
          init_cnt_r <= init_cnt_r + 2'h1;
          if (init_cnt_r == axis_ref_pkg::INIT_WAIT) begin
            sel_cap_r <= sel_s;
            cmd_raw_r <= enc_s;
            state_r   <= ST_IDLE;
            if (sel_s == 4'h0) begin
              origin_r <= enc_s;
            end else begin
              origin_r <= enc_s - (abs_s - ofs_counts);
            end
          end
        end
        ST_IDLE: begin
          if (cmd_go) begin
            case (cmd_op)
              axis_ref_pkg::OP_ABS: state_r <= ST_PLAN;
              axis_ref_pkg::OP_INC, axis_ref_pkg::OP_JOG: begin
                target_r <= cmd_raw_r + dest_r;
                state_r  <= ST_MOVE;
              end
              axis_ref_pkg::OP_HOME: begin
                homed_r    <= 1'b0;
                hdir_neg_r <= wb_dat_i[axis_ref_pkg::CMD_HNEG_BIT];
                state_r    <= ST_HSEARCH;
              end
              axis_ref_pkg::OP_RELOAD: begin
                init_cnt_r <= 2'h0;
                state_r    <= ST_INIT;
              end
              default: begin
              end
            endcase
          end
        end
        ST_PLAN: begin
          if (rt_valid) begin
            target_r <= cmd_raw_r + rt_delta;
            state_r  <= ST_MOVE;
          end
        end
        ST_MOVE: begin
          if (tick) begin
            if (cmd_raw_r == target_r) begin
              state_r <= ST_IDLE;
            end else if ($signed(cmd_raw_r) < $signed(target_r)) begin
              cmd_raw_r <= cmd_raw_r + 32'h1;
            end else begin
              cmd_raw_r <= cmd_raw_r - 32'h1;
            end
          end
        end
        ST_HSEARCH: begin
          if (trig) begin
            target_r <= enc_s + ofs_counts;
            state_r  <= ST_HOFFS;
          end else if (tick) begin
            cmd_raw_r <= hdir_neg_r ? cmd_raw_r - 32'h1 : cmd_raw_r + 32'h1;
          end
        end
        ST_HOFFS: begin
          if (tick) begin
            if (cmd_raw_r == target_r) begin
              origin_r <= cmd_raw_r;
              homed_r  <= 1'b1;
              state_r  <= ST_IDLE;
            end else if ($signed(cmd_raw_r) < $signed(target_r)) begin
              cmd_raw_r <= cmd_raw_r + 32'h1;
            end else begin
              cmd_raw_r <= cmd_raw_r - 32'h1;
            end
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_r <= 1'b0;
    end else begin
      busy_r <= state_r != ST_IDLE;
    end
  end
  assign busy_o    = busy_r;
  assign homed_o   = homed_r;
  assign cmd_pos_o = cmd_raw_r;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  ack_single_a : assert property (wb_fire |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle");
  step_unit_a : assert property ($past(state_r) != ST_INIT && cmd_raw_r != $past(cmd_raw_r) |->
    (cmd_raw_r - $past(cmd_raw_r) == 32'h1) || ($past(cmd_raw_r) - cmd_raw_r == 32'h1))
    else $error("step larger than one count");
  incr_zero_a : assert property (
    state_r == ST_INIT && init_cnt_r == 2'h3 && sel_s == 4'h0 |=> mpos == 32'h0 && apos == 32'h0)
    else $error("incremental position not zero");
  abs_load_a : assert property (
    state_r == ST_INIT && init_cnt_r == 2'h3 && sel_s != 4'h0 |=>
    apos == $past(abs_s) - $past(ofs_counts)) else $error("absolute position wrong");
  trig_capture_a : assert property (
    state_r == ST_HSEARCH && trig |=> state_r == ST_HOFFS &&
    target_r == $past(enc_s) + $past(ofs_counts)) else $error("trigger not captured");
  home_zero_a : assert property (
    state_r == ST_HOFFS && tick && cmd_raw_r == target_r |=> homed_o && mpos == 32'h0
    && state_r == ST_IDLE) else $error("home not zeroed");
  inc_exact_a : assert property (
    state_r == ST_IDLE && cmd_go && (cmd_op == 3'h2 || cmd_op == 3'h3) |=>
    target_r == $past(cmd_raw_r) + $past(dest_r)) else $error("incremental distance wrong");
  linear_abs_a : assert property (
    rt_start && rollover_range_param_r == 36'h0 |=> ##1 target_r - origin_r == $past(dest_r, 2))
    else $error("linear absolute target wrong");
  plan_once_a : assert property (
    rt_start |=> state_r == ST_PLAN && rt_valid ##1 state_r == ST_MOVE && !rt_valid)
    else $error("absolute plan not single");

  home_done_c : cover property (state_r == ST_HOFFS ##[1:1000] homed_o);
  roll_pos_c  : cover property (rt_start && rotary_r && !rollover_range_param_r[35] &&
                                rollover_range_param_r != 36'h0);
  roll_neg_c  : cover property (rt_start && rotary_r && rollover_range_param_r[35]);
  abs_init_c  : cover property (state_r == ST_INIT && sel_s != 4'h0 && init_cnt_r == 2'h3);
endmodule

// ---- testbench/motor_drive_model.sv ----
// motor drive stand-in: encoder trails the command, home flag at a fixed spot
`timescale 1ns/1ps
module motor_drive_model #(
  parameter int LAG      = 3,
  parameter int HOME_POS = 6,
  parameter int ABS_VAL  = 100
) (
  input  wire logic        clk_i,
  input  wire logic [31:0] cmd_pos_i,
  input  wire logic [1:0]  flag_ch_i,
  output logic [31:0]      enc_count_o,
  output logic [3:0]       home_flag_o,
  output logic [31:0]      abs_sensor_o
);
  logic [31:0] pipe_r [LAG];
  logic        hit;

  // the encoder lags three cycles, so following error is nonzero just after each step
  always_ff @(posedge clk_i) begin
    pipe_r[0] <= cmd_pos_i;
    for (int k = 1; k < LAG; k++) pipe_r[k] <= pipe_r[k-1];
  end

  assign enc_count_o  = pipe_r[LAG-1];
  assign hit          = $signed(enc_count_o) >= HOME_POS;
  // unselected channels read high, so a wrong channel choice trips at once
  assign home_flag_o  = hit ? 4'hF : ~(4'h1 << flag_ch_i);
  assign abs_sensor_o = 32'(ABS_VAL);
endmodule

// ---- testbench/home_offset_rotary_rollover_test.sv ----
// self-checking bench for the axis position-reference core
`timescale 1ns/1ps
module home_offset_rotary_rollover_test;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, busy_o, homed_o;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o, enc, abs_val, cmd_pos_o, rd, seed_r;
  logic [3:0]  flags, strap;
  int          failures, check_count, cur;
  int          cd [7] = '{5, 13, 2, -3, 1, 9, -9};
  int          cr [7] = '{0, 16, 16, -8, -8, 8, 8};
  int          rr [3] = '{12, -12, 0};

  axis_ref_core axis_ref_core_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hF),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .enc_count_i(enc),
    .home_flag_i(flags), .abs_sensor_i(abs_val), .abs_position_source_sel_i(strap),
    .cmd_pos_o(cmd_pos_o), .busy_o(busy_o), .homed_o(homed_o));
  motor_drive_model motor_drive_model_i (.clk_i(clk_i), .cmd_pos_i(cmd_pos_o),
    .flag_ch_i(2'h2), .enc_count_o(enc), .home_flag_o(flags), .abs_sensor_o(abs_val));

  // ----
  // helpers
  // ----
  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
    if (n == 50) begin
      failures++;
      give_verdict();
    end
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (2) @(posedge clk_i);
    while (busy_o !== 1'b0 && n < 20000) begin
      @(posedge clk_i);
      n++;
    end
    if (n == 20000) begin
      failures++;
      give_verdict();
    end
  endtask

  // shortest path, signed direction or linear, from the bench's own position
  function automatic logic [31:0] roll(input int c, dest, r, rot);
    int d;
    d = dest - c;
    if (rot != 0 && r > 0) begin
      d = ((d % r) + r) % r;
      if (d > r / 2) d -= r;
    end else if (rot != 0 && r < 0) begin
      d = ((d % -r) - r) % -r;
      if (dest < 0 && d != 0) d += r;
    end
    return 32'(c + d);
  endfunction

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic go(input logic [2:0] op, input int dest, r, rot);
    logic [31:0] exp;
    wb(1'b1, axis_ref_pkg::ROLL_LO_ADR, 32'(r)); // counts per revolution
    wb(1'b1, axis_ref_pkg::ROLL_HI_ADR, r < 0 ? 32'hF : 32'h0);
    wb(1'b1, axis_ref_pkg::CFG_ADR, rot != 0 ? 32'h12 : 32'h2);
    wb(1'b1, axis_ref_pkg::DEST_ADR, 32'(dest));
    wb(1'b1, axis_ref_pkg::CMD_ADR, {29'h0, op});
    wait_idle();
    exp = op == axis_ref_pkg::OP_ABS ? roll(cur, dest, r, rot) : 32'(cur + dest);
    wb(1'b0, axis_ref_pkg::MPOS_ADR, 32'h0);
    check(rd, exp);
    cur = $signed(exp);
  endtask

  task automatic home(input logic [31:0] fe, ofs, exp_raw, input logic neg);
    wb(1'b1, axis_ref_pkg::WARN_FE_ADR, fe);
    wb(1'b1, axis_ref_pkg::HOME_OFS_ADR, ofs);
    wb(1'b0, axis_ref_pkg::HOME_OFS_ADR, 32'h0);
    check(rd, ofs);
    wb(1'b1, axis_ref_pkg::CMD_ADR, {28'h0, neg, axis_ref_pkg::OP_HOME});
    wait_idle();
    check(cmd_pos_o, exp_raw);
    wb(1'b0, axis_ref_pkg::MPOS_ADR, 32'h0);
    check(rd, 32'h0);
    check({31'h0, homed_o}, 32'h1);
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end

  initial begin
    {rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {1'b1, 43'h0};
    strap = 4'h0;
    seed_r = 32'hCA98;
    cur = 0;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    wait_idle();
    wb(1'b0, axis_ref_pkg::MPOS_ADR, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, axis_ref_pkg::WARN_FE_ADR, 32'h0);
    check(rd, 32'h00001000);
    wb(1'b0, axis_ref_pkg::ROLL_LO_ADR, 32'h0);
    check(rd, 32'h0);
    wb(1'b0, 8'h40, 32'h0);
    check(rd, 32'h0);
    for (int k = 0; k < 7; k++) begin
      go(k == 5 ? axis_ref_pkg::OP_INC : k == 6 ? axis_ref_pkg::OP_JOG : axis_ref_pkg::OP_ABS,
         cd[k], cr[k], k != 2);
    end
    // minus one revolution asks for zero reached moving negatively
    go(axis_ref_pkg::OP_ABS, -8, -8, 1);
    for (int k = 0; k < 8; k++) begin
      seed_r = xorshift(seed_r);
      go(axis_ref_pkg::OP_ABS, int'(seed_r % 21) - 10, rr[seed_r % 3],
         seed_r[8]);
    end
    go(axis_ref_pkg::OP_ABS, -4, 0, 0);
    // first search runs negative and trips on following error, second on the flag
    home(32'h0, 32'hFFFFFFE0, 32'hFFFFFFFA, 1'b1);
    home(32'h00001000, 32'h00000030, 32'h00000009, 1'b0);
    strap <= 4'h5;
    wb(1'b1, axis_ref_pkg::HOME_OFS_ADR, 32'h00000070);
    wb(1'b1, axis_ref_pkg::CMD_ADR, {29'h0, axis_ref_pkg::OP_RELOAD});
    wait_idle();
    wb(1'b0, axis_ref_pkg::MPOS_ADR, 32'h0);
    check(rd, 32'd93);
    wb(1'b0, axis_ref_pkg::CMD_ADR, 32'h0);
    check({31'h0, rd[2]}, 32'h1);
    give_verdict();
  end
endmodule
